// ---- pkg/irsc_pkg.sv ----
// Shared constants, types and decode helpers for the interrupt, reset and sleep control block
package irsc_pkg;
	localparam int              ADDR_W     = 8;
	localparam int              DATA_W     = 32;
	localparam int              PEND_W     = 32;
	localparam logic [7:0]      OFF_CTRL   = 8'h00;
	localparam logic [7:0]      OFF_SLEEP  = 8'h04;
	localparam logic [7:0]      OFF_STAT   = 8'h08;
	localparam logic [15:0]     KEY_WRITE  = 16'h05fa;
	localparam logic [15:0]     KEY_READ   = 16'hfa05;
	localparam int              KEY_LSB    = 16;
	localparam int              ENDIAN_BIT = 15;
	localparam int              PRI_LSB    = 8;
	localparam int              PRI_MSB    = 10;
	localparam int              SYSREQ_BIT = 2;
	localparam int              CLRACT_BIT = 1;
	localparam int              LRST_BIT   = 0;
	localparam int              SEV_BIT    = 4;
	localparam int              DEEP_BIT   = 2;
	localparam int              SOE_BIT    = 1;
	localparam int              STAT_SLP   = 0;
	localparam int              STAT_DEEP  = 1;
	localparam int              STAT_REQ   = 2;
	localparam logic [2:0]      PRI_RST    = 3'h0;

	typedef enum logic [1:0] {
		IRSC_RUN   = 2'h1,
		IRSC_SLEEP = 2'h2
	} irsc_sleep_e;

	typedef struct packed {
		logic              we;
		logic              re;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} irsc_bus_s;

	typedef struct packed {
		logic              captured;
		logic              endian;
		logic [2:0]        pri_split;
		logic              sysreq;
		logic              clr_act;
		logic              lrst;
		logic              pend_wake;
		logic              deep_sel;
		logic              sleep_exit;
		irsc_sleep_e       sleep_st;
		logic              deep_now;
		logic [DATA_W-1:0] rdata;
	} irsc_state_s;

	localparam irsc_state_s STATE_RST = '{
		captured:   1'b0,
		endian:     1'b0,
		pri_split:  PRI_RST,
		sysreq:     1'b0,
		clr_act:    1'b0,
		lrst:       1'b0,
		pend_wake:  1'b0,
		deep_sel:   1'b0,
		sleep_exit: 1'b0,
		sleep_st:   IRSC_RUN,
		deep_now:   1'b0,
		rdata:      32'h0
	};

	typedef struct packed {
		logic [PEND_W-1:0] pend_prev;
		logic              wake;
	} irsc_wake_s;

	localparam irsc_wake_s WAKE_RST = '{pend_prev: 32'h0, wake: 1'b0};

	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction
endpackage

// ---- core/irsc_key_check.sv ----
// Write decode with key check for the control register; sleep register writes are not keyed
`timescale 1ns/1ps
`default_nettype none
module irsc_key_check (
	input  wire irsc_pkg::irsc_bus_s i_bus,
	output logic                     o_ctrl_keyed,
	output logic                     o_sleep_wr
);
	// Only a write with the key in the upper half changes the control register
	assign o_ctrl_keyed = i_bus.we && irsc_pkg::addr_is(i_bus.addr, irsc_pkg::OFF_CTRL)
		&& (i_bus.wdata[31:16] == irsc_pkg::KEY_WRITE);
	assign o_sleep_wr   = i_bus.we && irsc_pkg::addr_is(i_bus.addr, irsc_pkg::OFF_SLEEP);
endmodule
`default_nettype wire

// ---- core/irsc_wake_detect.sv ----
// Pending-edge wake event detector
`timescale 1ns/1ps
`default_nettype none
module irsc_wake_detect (
	input  wire logic                        i_clock,
	input  wire logic                        i_rst,
	input  wire logic                        i_enable,
	input  wire logic [irsc_pkg::PEND_W-1:0] i_pend,
	output logic                             o_wake_event
);
	irsc_pkg::irsc_wake_s state_r;
	irsc_pkg::irsc_wake_s state_nxt;

	always_comb begin
		state_nxt           = state_r;
		state_nxt.pend_prev = i_pend;
		// Inactive to pending counts only when enabled
		state_nxt.wake      = i_enable && (|(i_pend & ~state_r.pend_prev));
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_r <= irsc_pkg::WAKE_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_wake_event = state_r.wake;

	a_wake_on_rise: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_enable && (|(i_pend & ~state_r.pend_prev))) |=> o_wake_event)
		else $error("pending rise with wake enabled gave no wake event");
	a_wake_disabled: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_enable |=> !o_wake_event)
		else $error("wake event while pending wake disabled");
endmodule
`default_nettype wire

// ---- core/irsc_top.sv ----
// Interrupt, reset and sleep control registers with sleep state tracking
`timescale 1ns/1ps
`default_nettype none
module irsc_top #(
	parameter bit DEEP_IMPL = 1'b1
) (
	input  wire logic                        i_clock,
	input  wire logic                        i_rst,
	input  wire logic [irsc_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [irsc_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                        i_we,
	input  wire logic                        i_re,
	input  wire logic                        i_endian_cfg,
	input  wire logic [irsc_pkg::PEND_W-1:0] i_pend,
	input  wire logic                        i_sleep_req,
	input  wire logic                        i_return_to_thread,
	input  wire logic                        i_wake,
	output logic [irsc_pkg::DATA_W-1:0]      o_rdata,
	output logic                             o_ext_reset_req,
	output logic                             o_clear_active,
	output logic                             o_local_reset,
	output logic                             o_sleeping,
	output logic                             o_sleep_deep,
	output logic                             o_wake_event
);
	irsc_pkg::irsc_bus_s   bus;
	irsc_pkg::irsc_state_s state_r;
	irsc_pkg::irsc_state_s state_nxt;
	logic                  ctrl_keyed;
	logic                  sleep_wr;
	logic                  wake_evt;
	logic                  kw_sysreq;
	logic                  kw_clr;
	logic                  kw_lrst;

	assign bus.we    = i_we;
	assign bus.re    = i_re;
	assign bus.addr  = i_addr;
	assign bus.wdata = i_wdata;

	irsc_key_check u_key (
		.i_bus         (bus),
		.o_ctrl_keyed  (ctrl_keyed),
		.o_sleep_wr    (sleep_wr)
	);

	irsc_wake_detect u_wake (
		.i_clock      (i_clock),
		.i_rst        (i_rst),
		.i_enable     (state_r.pend_wake),
		.i_pend       (i_pend),
		.o_wake_event (wake_evt)
	);

	assign kw_sysreq = ctrl_keyed && i_wdata[irsc_pkg::SYSREQ_BIT];
	assign kw_clr    = ctrl_keyed && i_wdata[irsc_pkg::CLRACT_BIT];
	assign kw_lrst   = ctrl_keyed && i_wdata[irsc_pkg::LRST_BIT];

	always_comb begin
		state_nxt         = state_r;
		state_nxt.clr_act = 1'b0;
		state_nxt.lrst    = 1'b0;
		state_nxt.rdata   = '0;

		// Byte order caught once after reset release
		if (!state_r.captured) begin
			state_nxt.captured = 1'b1;
			state_nxt.endian   = i_endian_cfg;
		end

		if (ctrl_keyed) begin
			state_nxt.pri_split = i_wdata[irsc_pkg::PRI_MSB:irsc_pkg::PRI_LSB];
			state_nxt.clr_act  = i_wdata[irsc_pkg::CLRACT_BIT];
			state_nxt.lrst     = i_wdata[irsc_pkg::LRST_BIT];
			if (i_wdata[irsc_pkg::SYSREQ_BIT]) begin
				state_nxt.sysreq = 1'b1;
			end
		end
		// Local reset wins over a request made in the same cycle
		if (state_r.lrst) begin
			state_nxt.sysreq = 1'b0;
		end

		if (sleep_wr) begin
			state_nxt.pend_wake  = i_wdata[irsc_pkg::SEV_BIT];
			state_nxt.deep_sel   = DEEP_IMPL && i_wdata[irsc_pkg::DEEP_BIT];
			state_nxt.sleep_exit = i_wdata[irsc_pkg::SOE_BIT];
		end

		if (i_re) begin
			if (irsc_pkg::addr_is(i_addr, irsc_pkg::OFF_CTRL)) begin
				state_nxt.rdata[31:irsc_pkg::KEY_LSB] = irsc_pkg::KEY_READ;
				state_nxt.rdata[irsc_pkg::ENDIAN_BIT] = state_r.endian;
				state_nxt.rdata[irsc_pkg::PRI_MSB:irsc_pkg::PRI_LSB] = state_r.pri_split;
				state_nxt.rdata[irsc_pkg::SYSREQ_BIT] = state_r.sysreq;
				// Clear and local reset bits are one-cycle pulses and read zero
			end else if (irsc_pkg::addr_is(i_addr, irsc_pkg::OFF_SLEEP)) begin
				state_nxt.rdata[irsc_pkg::SEV_BIT]  = state_r.pend_wake;
				state_nxt.rdata[irsc_pkg::DEEP_BIT] = state_r.deep_sel;
				state_nxt.rdata[irsc_pkg::SOE_BIT]  = state_r.sleep_exit;
			end else if (irsc_pkg::addr_is(i_addr, irsc_pkg::OFF_STAT)) begin
				state_nxt.rdata[irsc_pkg::STAT_SLP]  = state_r.sleep_st[1];
				state_nxt.rdata[irsc_pkg::STAT_DEEP] = state_r.deep_now;
				state_nxt.rdata[irsc_pkg::STAT_REQ]  = state_r.sysreq;
			end
		end

		// Sleep tracking
		case (state_r.sleep_st)
			irsc_pkg::IRSC_RUN: begin
				if (i_sleep_req || (i_return_to_thread && state_r.sleep_exit)) begin
					state_nxt.sleep_st = irsc_pkg::IRSC_SLEEP;
					state_nxt.deep_now = state_r.deep_sel;
				end
			end
			irsc_pkg::IRSC_SLEEP: begin
				if (wake_evt || i_wake) begin
					state_nxt.sleep_st = irsc_pkg::IRSC_RUN;
					state_nxt.deep_now = 1'b0;
				end
			end
			default: begin
				state_nxt.sleep_st = irsc_pkg::IRSC_RUN;
				state_nxt.deep_now = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_r <= irsc_pkg::STATE_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_rdata         = state_r.rdata;
	assign o_ext_reset_req = state_r.sysreq;
	assign o_clear_active  = state_r.clr_act;
	assign o_local_reset   = state_r.lrst;
	assign o_sleeping      = state_r.sleep_st[1];
	assign o_sleep_deep    = state_r.deep_now;
	assign o_wake_event    = wake_evt;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	a_key_bad_ignored: assert property (
		(i_we && irsc_pkg::addr_is(i_addr, irsc_pkg::OFF_CTRL)
			&& (i_wdata[31:16] != irsc_pkg::KEY_WRITE))
		|=> ($stable(state_r.pri_split) && !o_clear_active && !o_local_reset))
		else $error("unkeyed write changed the control register");
	a_key_readback: assert property (
		(i_re && irsc_pkg::addr_is(i_addr, irsc_pkg::OFF_CTRL))
		|=> (o_rdata[31:16] == irsc_pkg::KEY_READ) && (o_rdata[1:0] == 2'h0))
		else $error("control register read lacks key pattern or shows write-only bits");
	a_endian_hold: assert property (
		state_r.captured |=> $stable(state_r.endian))
		else $error("byte order flag changed after capture");
	a_pri_split_load: assert property (
		ctrl_keyed |=> (state_r.pri_split == $past(i_wdata[10:8])))
		else $error("priority split point not loaded by keyed write");
	a_sysreq_set: assert property (
		(kw_sysreq && !o_local_reset) |=> o_ext_reset_req)
		else $error("external reset request not raised");
	a_sysreq_clear: assert property (
		o_local_reset |=> !o_ext_reset_req)
		else $error("local reset left external request high");
	a_clear_pulse: assert property (
		kw_clr |=> o_clear_active)
		else $error("clear of active exceptions not pulsed");
	a_local_reset_self: assert property (
		o_local_reset |-> $past(kw_lrst))
		else $error("local reset pulse without keyed write or not self-clearing");
	a_sleep_on_return: assert property (
		(!o_sleeping && i_return_to_thread && state_r.sleep_exit) |=> o_sleeping)
		else $error("no sleep on return to thread level");
	a_deep_only_asleep: assert property (
		!o_sleeping |-> !o_sleep_deep)
		else $error("deep sleep shown while awake");
endmodule
`default_nettype wire

// ---- sim/irsc_reset_ctrl_model.sv ----
// Behavioural model of the external system reset controller
`timescale 1ns/1ps
`default_nettype none
module irsc_reset_ctrl_model #(
	parameter int DELAY = 8
) (
	input  wire logic i_clock,
	input  wire logic i_req,
	output logic      o_sys_rst
);
	int cnt = 0;
	initial o_sys_rst = 1'b0;
	// Answers a held request with a system reset after DELAY+1 cycles
	always @(posedge i_clock) begin
		cnt <= i_req ? cnt + 1 : 0;
		o_sys_rst <= i_req && cnt >= DELAY;
	end
endmodule
`default_nettype wire

// ---- sim/irsc_tb_top.sv ----
// Self-checking bench for the interrupt, reset and sleep control block
`timescale 1ns/1ps
`default_nettype none
module irsc_tb_top;
	logic        clk     = 1'b0;
	logic        rst     = 1'b1;
	logic        sys_rst;
	logic [7:0]  addr    = 8'h00;
	logic [31:0] wdata   = 32'h0;
	logic        we      = 1'b0;
	logic        re      = 1'b0;
	logic        endian  = 1'b1;
	logic [31:0] pend    = 32'h0;
	logic        slp     = 1'b0;
	logic        ret     = 1'b0;
	logic        wk      = 1'b0;
	logic [31:0] rdata;
	logic        req;
	logic        clr;
	logic        lrst;
	logic        sleeping;
	logic        deep;
	logic        wev;
	int          error_cnt = 0;
	int          n_tests   = 0;
	int          cycles    = 0;
	int          wakes     = 0;
	logic [31:0] rd;
	logic [31:0] v;
	logic [2:0]  pri;

	always #25 clk = ~clk;

	irsc_top i_irsc_top (.i_clock(clk), .i_rst(rst | sys_rst), .i_addr(addr),
		.i_wdata(wdata), .i_we(we), .i_re(re), .i_endian_cfg(endian), .i_pend(pend),
		.i_sleep_req(slp), .i_return_to_thread(ret), .i_wake(wk), .o_rdata(rdata),
		.o_ext_reset_req(req), .o_clear_active(clr), .o_local_reset(lrst),
		.o_sleeping(sleeping), .o_sleep_deep(deep), .o_wake_event(wev));

	irsc_reset_ctrl_model i_irsc_reset_ctrl_model (.i_clock(clk), .i_req(req),
		.o_sys_rst(sys_rst));

	task automatic tally_and_finish;
		$display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (wev === 1'b1)
			wakes++;
		if (cycles == 2000) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t timeout", $time);
			tally_and_finish();
		end
	end

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string m);
		chk_word({31'h0, got}, {31'h0, exp}, m);
	endtask

	function automatic logic [31:0] ctrl_exp(input logic e, input logic [2:0] p, input logic r);
		return {16'hfa05, e, 4'h0, p, 5'h00, r, 2'b00};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
		#1;
	endtask

	task automatic rdw(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic pulse(input int k);
		@(posedge clk);
		{slp, ret, wk} <= 3'b100 >> k;
		@(posedge clk);
		{slp, ret, wk} <= 3'b000;
		#1;
	endtask

	// Debug halt is assumed around writes of bits 1 and 0
	initial begin
		void'($urandom(72));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		@(posedge clk);
		endian <= 1'b0;
		rdw(8'h00, rd);
		chk_word(rd, ctrl_exp(1'b1, 3'h0, 1'b0), "control after reset");
		repeat (4) begin
			v = $urandom;
			if (v[31:16] == 16'h05fa)
				v[31:16] = 16'h1234;
			wr(8'h00, v);
			rdw(8'h00, rd);
			chk_word(rd, ctrl_exp(1'b1, 3'h0, 1'b0), "bad key");
		end
		pri = $urandom;
		wr(8'h00, {16'h05fa, 1'b0, 4'hf, pri, 5'h1f, 3'b000});
		rdw(8'h00, rd);
		chk_word(rd, ctrl_exp(1'b1, pri, 1'b0), "priority and byte order");
		wr(8'h00, {16'h05fa, 5'h00, pri, 8'h02});
		chk_bit(clr, 1'b1, "clear pulse");
		@(posedge clk);
		#1 chk_bit(clr, 1'b0, "clear ends");
		rdw(8'h00, rd);
		chk_word(rd, ctrl_exp(1'b1, pri, 1'b0), "write-only bits");
		wr(8'h00, {16'h05fa, 5'h00, pri, 8'h04});
		chk_bit(req, 1'b1, "reset request");
		wr(8'h00, {16'h05fa, 5'h00, pri, 8'h01});
		chk_bit(lrst, 1'b1, "local reset");
		@(posedge clk);
		#1 chk_bit(lrst, 1'b0, "local reset clears");
		chk_bit(req, 1'b0, "request cleared locally");
		wr(8'h00, {16'h05fa, 5'h00, pri, 8'h04});
		repeat (14) @(posedge clk);
		#1 chk_bit(req, 1'b0, "request cleared by reset");
		rdw(8'h00, rd);
		chk_word(rd, ctrl_exp(1'b0, 3'h0, 1'b0), "fields after reset");
		for (int i = 0; i < 3; i++) begin
			v = $urandom;
			wr(8'h04, v);
			rdw(8'h04, rd);
			chk_word(rd, v & 32'h16, "sleep register");
		end
		rdw(8'h0c, rd);
		chk_word(rd, 32'h0, "unmapped");
		wr(8'h04, 32'h14);
		pulse(0);
		chk_bit(sleeping, 1'b1, "asleep");
		chk_bit(deep, 1'b1, "deep");
		rdw(8'h08, rd);
		chk_word(rd, 32'h3, "status");
		v = wakes;
		@(posedge clk);
		pend <= 32'h1 << ($urandom % 32);
		repeat (4) @(posedge clk);
		#1 chk_word(wakes - v, 32'h1, "one wake event");
		chk_bit(sleeping, 1'b0, "woken by pending");
		@(posedge clk);
		pend <= 32'h0;
		wr(8'h04, 32'h02);
		pulse(1);
		chk_bit(sleeping, 1'b1, "sleep on return");
		chk_bit(deep, 1'b0, "shallow");
		v = wakes;
		@(posedge clk);
		pend <= $urandom | 32'h1;
		repeat (4) @(posedge clk);
		#1 chk_word(wakes - v, 32'h0, "no wake event");
		chk_bit(sleeping, 1'b1, "still asleep");
		pulse(2);
		chk_bit(sleeping, 1'b0, "woken");
		wr(8'h04, 32'h0);
		pulse(1);
		chk_bit(sleeping, 1'b0, "no sleep on return");
		tally_and_finish();
	end
endmodule
`default_nettype wire
